/* include/tsh_regs.vh */
`ifndef TSH_REGS_VH
`define TSH_REGS_VH
// ****************************************
// register offsets
// ****************************************
`define TSH_A_STAT   8'h88
`define TSH_A_CMD    8'h8c
`define TSH_A_WFIFO  8'h8d
`define TSH_A_CTRL   8'h8e
`define TSH_A_RFIFO  8'h8f
`define TSH_A_ISTAT  8'h98
`define TSH_A_ICLR   8'h99
`define TSH_A_IEN    8'h9a
`define TSH_A_MODE   8'h9b
// ****************************************
// field positions
// ****************************************
`define TSH_C_RATE_HI 7
`define TSH_C_RATE_LO 6
`define TSH_C_AUTO    5
`define TSH_C_FCSAB   4
`define TSH_C_PCLR    3
`define TSH_C_CONT    2
`define TSH_C_SEL     1
`define TSH_C_START   0
`define TSH_S_BUSY    0
`define TSH_S_DONE    1
`define TSH_S_FCS     3
`define TSH_S_KILL    4
`define TSH_S_CONT    6
`define TSH_I_DONE    0
`define TSH_I_KILL    1
`define TSH_I_ABORT   2
// ****************************************
// reset values and timing
// ****************************************
`define TSH_RST_BYTE  8'h00
`define TSH_WDEPTH    7
`define TSH_RDEPTH    16
`define TSH_CLK_HZ    100000000
`define TSH_RATE_HZ   32
`define TSH_T32_CYC   (`TSH_CLK_HZ / `TSH_RATE_HZ)
`endif

/* verilog/tsh_host_regs.v */
`timescale 1ns/100ps
`include "tsh_regs.vh"
module tsh_host_regs #(
  parameter integer TICK_CYC = `TSH_T32_CYC
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // register port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // transaction engine, same clock
  input  wire       xfer_done,
  input  wire       xfer_stop,
  input  wire       xfer_fcs_err,
  input  wire       xfer_contention,
  input  wire       xfer_wpop,
  input  wire       xfer_rx_valid,
  input  wire [7:0] xfer_rx_data,
  output reg        xfer_start,
  output reg        xfer_abort,
  output reg  [7:0] host_command_byte,
  output reg  [7:0] xfer_wbyte,
  output reg        alt_sideband_mode,
  output reg        idle_level_or_width_select,
  // interrupt
  output reg        irq
);

// ****************************************
// state
// ****************************************
reg  [7:0]  cmd_ff;
reg  [7:0]  ctrl_ff;
reg         mode_ff;
reg         busy_ff;
reg         done_ff;
reg         kill_ff;
reg         fcs_ff;
reg         cont_ff;
reg  [2:0]  ist_ff;
reg  [2:0]  ien_ff;
reg  [7:0]  wfifo [0:`TSH_WDEPTH-1];
reg  [7:0]  rfifo [0:`TSH_RDEPTH-1];
reg  [2:0]  wp_ff;
reg  [2:0]  ep_ff;
reg  [3:0]  rp_ff;
reg  [4:0]  rxp_ff;
reg  [21:0] tick_ff;
reg  [2:0]  div_ff;
reg  [7:0]  rdata_nxt;
integer     i;

// ****************************************
// decode
// ****************************************
wire wr_cmd   = reg_wr && (reg_addr == `TSH_A_CMD);
wire wr_wfifo = reg_wr && (reg_addr == `TSH_A_WFIFO);
wire wr_ctrl  = reg_wr && (reg_addr == `TSH_A_CTRL);
wire wr_stat  = reg_wr && (reg_addr == `TSH_A_STAT);
wire wr_iclr  = reg_wr && (reg_addr == `TSH_A_ICLR);
wire wr_ien   = reg_wr && (reg_addr == `TSH_A_IEN);
wire wr_mode  = reg_wr && (reg_addr == `TSH_A_MODE);
wire rd_rfifo = reg_rd && (reg_addr == `TSH_A_RFIFO);

// ****************************************
// launch, kill and abort
// ****************************************
wire sw_start = wr_ctrl && reg_wdata[`TSH_C_START] && !busy_ff;
wire sw_kill  = wr_ctrl && !reg_wdata[`TSH_C_START] && busy_ff;
wire pclr     = wr_ctrl && reg_wdata[`TSH_C_PCLR];

// base tick at the fastest rate; slower rates gate it
wire tick_hit = (tick_ff == TICK_CYC[21:0] - 22'h00_0001);
reg  [2:0] rate_mask;
always @* begin
  case (ctrl_ff[`TSH_C_RATE_HI:`TSH_C_RATE_LO])
    2'b00:   rate_mask = 3'h0;
    2'b01:   rate_mask = 3'h1;
    2'b10:   rate_mask = 3'h3;
    default: rate_mask = 3'h7;
  endcase
end
wire auto_hit = tick_hit && ((div_ff & rate_mask) == 3'h0);
// a due launch during a transfer is dropped, not queued
wire auto_go  = ctrl_ff[`TSH_C_AUTO] && auto_hit && !busy_ff;
wire go       = sw_start || auto_go;

// check error abort only applies to the single-wire mode
wire fcs_ab  = busy_ff && !mode_ff && xfer_fcs_err && ctrl_ff[`TSH_C_FCSAB];
wire cont_ab = busy_ff && !mode_ff && xfer_contention && ctrl_ff[`TSH_C_CONT];
wire hw_ab   = fcs_ab || cont_ab;

// ****************************************
// periodic timer
// ****************************************
always @(posedge clk) begin
  if (!rst_n) begin
    tick_ff <= 22'h00_0000;
    div_ff  <= 3'h0;
  end else if (tick_hit) begin
    tick_ff <= 22'h00_0000;
    div_ff  <= div_ff + 3'h1;
  end else begin
    tick_ff <= tick_ff + 22'h00_0001;
  end
end

// ****************************************
// control registers
// ****************************************
always @(posedge clk) begin
  if (!rst_n) begin
    cmd_ff  <= `TSH_RST_BYTE;
    ctrl_ff <= `TSH_RST_BYTE;
    mode_ff <= 1'b0;
    ien_ff  <= 3'h0;
  end else begin
    // stored as written, control without its start and clear bits; stability while busy is up to software
    if (wr_cmd)
      cmd_ff <= reg_wdata;
    if (wr_ctrl)
      ctrl_ff <= reg_wdata & 8'hf6;
    if (wr_mode)
      mode_ff <= reg_wdata[0];
    if (wr_ien)
      ien_ff <= reg_wdata[2:0];
  end
end

// ****************************************
// busy and status flags
// ****************************************
always @(posedge clk) begin
  if (!rst_n) begin
    busy_ff <= 1'b0;
    done_ff <= 1'b0;
    kill_ff <= 1'b0;
    fcs_ff  <= 1'b0;
    cont_ff <= 1'b0;
  end else begin
    if (go)
      busy_ff <= 1'b1;
    else if (xfer_done || sw_kill || hw_ab)
      busy_ff <= 1'b0;
    // set wins over a write-one clear in the same cycle
    if (xfer_stop)
      done_ff <= 1'b1;
    else if (wr_stat && reg_wdata[`TSH_S_DONE])
      done_ff <= 1'b0;
    if (sw_kill)
      kill_ff <= 1'b1;
    else if (wr_stat && reg_wdata[`TSH_S_KILL])
      kill_ff <= 1'b0;
    if (fcs_ab)
      fcs_ff <= 1'b1;
    else if (wr_stat && reg_wdata[`TSH_S_FCS])
      fcs_ff <= 1'b0;
    if (cont_ab)
      cont_ff <= 1'b1;
    else if (wr_stat && reg_wdata[`TSH_S_CONT])
      cont_ff <= 1'b0;
  end
end

// ****************************************
// interrupt status
// ****************************************
wire [2:0] iev = {hw_ab, sw_kill, xfer_stop};
always @(posedge clk) begin
  if (!rst_n) begin
    ist_ff <= 3'h0;
    irq    <= 1'b0;
  end else begin
    if (wr_iclr)
      ist_ff <= (ist_ff & ~reg_wdata[2:0]) | iev;
    else
      ist_ff <= ist_ff | iev;
    irq <= |(ist_ff & ien_ff);
  end
end

// ****************************************
// write fifo
// ****************************************
always @(posedge clk) begin
  if (!rst_n) begin
    wp_ff <= 3'h0;
    for (i = 0; i < `TSH_WDEPTH; i = i + 1)
      wfifo[i] <= `TSH_RST_BYTE;
  end else if (pclr) begin
    wp_ff <= 3'h0;
  end else if (wr_wfifo && (wp_ff < 3'h7)) begin
    wfifo[wp_ff] <= reg_wdata;
    wp_ff        <= wp_ff + 3'h1;
  end
end

// engine side walks the same entries from the front
always @(posedge clk) begin
  if (!rst_n)
    ep_ff <= 3'h0;
  else if (go)
    ep_ff <= 3'h0;
  else if (xfer_wpop && (ep_ff < 3'h6))
    ep_ff <= ep_ff + 3'h1;
end

// ****************************************
// read fifo
// ****************************************
always @(posedge clk) begin
  if (!rst_n) begin
    rxp_ff <= 5'h00;
    for (i = 0; i < `TSH_RDEPTH; i = i + 1)
      rfifo[i] <= `TSH_RST_BYTE;
  end else if (go) begin
    rxp_ff <= 5'h00;
  end else if (xfer_rx_valid && !rxp_ff[4]) begin
    rfifo[rxp_ff[3:0]] <= xfer_rx_data;
    rxp_ff             <= rxp_ff + 5'h01;
  end
end

// wraps after byte sixteen
always @(posedge clk) begin
  if (!rst_n)
    rp_ff <= 4'h0;
  else if (pclr)
    rp_ff <= 4'h0;
  else if (rd_rfifo)
    rp_ff <= rp_ff + 4'h1;
end

// ****************************************
// read mux
// ****************************************
always @* begin
  rdata_nxt = 8'h00;
  case (reg_addr)
    `TSH_A_STAT:  rdata_nxt = {1'b0, cont_ff, 1'b0, kill_ff, fcs_ff, 1'b0,
                               done_ff, busy_ff};
    `TSH_A_CMD:   rdata_nxt = cmd_ff;
    `TSH_A_WFIFO: rdata_nxt = wfifo[(wp_ff < 3'h7) ? wp_ff : 3'h6];
    `TSH_A_CTRL:  rdata_nxt = ctrl_ff;
    `TSH_A_RFIFO: rdata_nxt = rfifo[rp_ff];
    `TSH_A_ISTAT: rdata_nxt = {5'h00, ist_ff};
    `TSH_A_IEN:   rdata_nxt = {5'h00, ien_ff};
    `TSH_A_MODE:  rdata_nxt = {7'h00, mode_ff};
    default:      rdata_nxt = 8'h00;
  endcase
end

always @(posedge clk) begin
  if (!rst_n)
    reg_rdata <= 8'h00;
  else if (reg_rd)
    reg_rdata <= rdata_nxt;
  else
    reg_rdata <= 8'h00;
end

// ****************************************
// engine outputs
// ****************************************
always @(posedge clk) begin
  if (!rst_n) begin
    xfer_start                 <= 1'b0;
    xfer_abort                 <= 1'b0;
    host_command_byte          <= `TSH_RST_BYTE;
    xfer_wbyte                 <= `TSH_RST_BYTE;
    alt_sideband_mode          <= 1'b0;
    idle_level_or_width_select <= 1'b0;
  end else begin
    xfer_start                 <= go;
    xfer_abort                 <= sw_kill || hw_ab;
    // command field in both modes, passed through in the cycle it is written
    host_command_byte          <= wr_cmd ? reg_wdata : cmd_ff;
    xfer_wbyte                 <= wfifo[ep_ff];
    alt_sideband_mode          <= wr_mode ? reg_wdata[0] : mode_ff;
    idle_level_or_width_select <= wr_ctrl ? reg_wdata[`TSH_C_SEL]
                                          : ctrl_ff[`TSH_C_SEL];
  end
end

endmodule // tsh_host_regs

/* verification/tsh_checker.sv */
`timescale 1ns/100ps
// ****
// checker
// ****
module tsh_checker (
  // clock and reset
  input wire       clk,
  input wire       rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  // engine side
  input wire       xfer_start,
  input wire       xfer_abort,
  input wire       xfer_done,
  input wire [7:0] host_command_byte,
  input wire       idle_level_or_width_select
);
  reg  bsy_ff;
  reg  auto_ff;
  wire ctl_wr = reg_wr && reg_addr == 8'h8e;
  // busy stays up through the done cycle; a kill drops it in the cycle abort shows
  wire busy = xfer_start | (bsy_ff & ~xfer_abort);
  always @(posedge clk) begin
    bsy_ff  <= rst_n & busy & ~xfer_done;
    auto_ff <= rst_n & (ctl_wr ? reg_wdata[5] : auto_ff);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_go; ctl_wr && reg_wdata[0] && !busy |=> xfer_start; endproperty
  a_go: assert property (p_go) else $error("start missed");
  property p_ign; ctl_wr && reg_wdata[0] && busy |=> !xfer_start; endproperty
  a_ign: assert property (p_ign) else $error("start while busy");
  property p_kill; ctl_wr && !reg_wdata[0] && busy |=> xfer_abort; endproperty
  a_kill: assert property (p_kill) else $error("kill missed");
  property p_spul; xfer_start |=> !xfer_start; endproperty
  a_spul: assert property (p_spul) else $error("start too long");
  property p_apul; xfer_abort |=> !xfer_abort; endproperty
  a_apul: assert property (p_apul) else $error("abort too long");
  property p_cmd;
    reg_wr && reg_addr == 8'h8c |=> host_command_byte == $past(reg_wdata);
  endproperty
  a_cmd: assert property (p_cmd) else $error("command byte");
  property p_ctlrd; reg_rd && reg_addr == 8'h8e |=> !reg_rdata[3] && !reg_rdata[0]; endproperty
  a_ctlrd: assert property (p_ctlrd) else $error("control readback");
  property p_sel; ctl_wr |=> idle_level_or_width_select == $past(reg_wdata[1]); endproperty
  a_sel: assert property (p_sel) else $error("select bit");
  property p_noauto; !auto_ff && !(ctl_wr && reg_wdata[0]) |=> !xfer_start; endproperty
  a_noauto: assert property (p_noauto) else $error("stray start");
endmodule // tsh_checker
bind tsh_host_regs tsh_checker chk_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .xfer_start(xfer_start), .xfer_abort(xfer_abort), .xfer_done(xfer_done),
  .host_command_byte(host_command_byte),
  .idle_level_or_width_select(idle_level_or_width_select));

/* verification/tsh_engine_model.sv */
`timescale 1ns/100ps
// ****
// engine model: 7 pops, 17 bytes, stop, done
// ****
module tsh_engine_model (
  // clock and reset
  input wire       clk,
  input wire       rst_n,
  // control
  input wire       slow,
  input wire       xfer_start,
  input wire       xfer_abort,
  // answers
  output reg       xfer_done,
  output reg       xfer_stop,
  output reg       xfer_wpop,
  output reg       xfer_rx_valid,
  output reg [7:0] xfer_rx_data
);
  reg  [7:0] cnt_ff;
  wire [7:0] b = slow ? 8'h3c : 8'h02;
  always @(posedge clk) begin
    if (!rst_n || xfer_abort || cnt_ff == b + 25)
      cnt_ff <= 8'h00;
    else if (xfer_start || cnt_ff != 0)
      cnt_ff <= cnt_ff + 8'h01;
    xfer_wpop     <= cnt_ff >= b && cnt_ff < b + 7;
    // one byte past sixteen, to be dropped
    xfer_rx_valid <= cnt_ff >= b + 7 && cnt_ff < b + 24;
    // changes every cycle, so a stale sample shows
    xfer_rx_data  <= 8'ha0 + cnt_ff - b - 8'h07;
    xfer_stop     <= cnt_ff == b + 24;
    xfer_done     <= cnt_ff == b + 25 || xfer_abort;
  end
endmodule // tsh_engine_model

/* verification/tb.sv */
`timescale 1ns/100ps
module tb;
  logic       clk, rst_n, reg_wr, reg_rd, slow, look;
  logic       fcs, cont, done, stop, wpop, rxv, st, ab, irq, mo;
  logic [7:0] reg_addr, reg_wdata, rdata, rxd, n_st, s, w0, w6, r, wb;
  logic [7:0] q[$];
  int         n_fail, n_tests, i, k;
  tsh_host_regs #(.TICK_CYC(20)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
    .xfer_done(done), .xfer_stop(stop), .xfer_fcs_err(fcs), .xfer_contention(cont),
    .xfer_wpop(wpop), .xfer_rx_valid(rxv), .xfer_rx_data(rxd), .xfer_start(st),
    .xfer_abort(ab), .host_command_byte(), .xfer_wbyte(wb), .alt_sideband_mode(mo),
    .idle_level_or_width_select(), .irq(irq));
  tsh_engine_model eng_u (.clk(clk), .rst_n(rst_n), .slow(slow), .xfer_start(st),
    .xfer_abort(ab), .xfer_done(done), .xfer_stop(stop), .xfer_wpop(wpop),
    .xfer_rx_valid(rxv), .xfer_rx_data(rxd));
  // ****
  // tasks
  // ****
  task chk(input [7:0] g, input [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1; @(posedge clk);
    reg_wr <= 0; @(posedge clk);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    q.push_back(e); reg_addr <= a; reg_rd <= 1; @(posedge clk);
    reg_rd <= 0; @(posedge clk);
  endtask
  task wt;
    for (k = 0; k < 200 && done !== 1'b1; k++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task stop_test;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ****
  // monitor, clock, watchdog
  // ****
  always @(negedge clk) begin
    if (look) chk(rdata, q.pop_front());
    look = reg_rd;
  end
  always @(posedge clk) if (st) n_st <= n_st + 8'h01;
  initial begin clk = 0; forever #5 clk = ~clk; end
  initial begin #200000; n_fail++; stop_test; end
  // ****
  // tests
  // ****
  initial begin
    {rst_n, reg_wr, reg_rd, slow, look, fcs, cont} = 0;
    {reg_addr, reg_wdata, n_st} = 0;
    r = $urandom(48404);
    repeat (16) @(posedge clk);
    rst_n <= 1; @(posedge clk);
    rd(8'h8c, 8'h00); rd(8'h8e, 8'h00); rd(8'h88, 8'h00);
    $display("reset values done");
    for (i = 0; i < 3; i++) begin
      r = i == 0 ? $urandom : (i == 1 ? 8'h03 : 8'hff);
      wr(8'h8c, r); rd(8'h8c, r);
    end
    $display("command byte done");
    for (i = 0; i < 7; i++) begin
      r = $urandom; if (i == 0) w0 = r; if (i == 6) w6 = r; wr(8'h8d, r);
    end
    wr(8'h8e, 8'h08); rd(8'h8d, w0); rd(8'h8e, 8'h00);
    $display("write fifo done");
    wr(8'h9a, 8'h01); rd(8'h88, 8'h00);
    wr(8'h8e, 8'h03); wt; rd(8'h88, 8'h02); chk(irq, 1);
    chk(wb, w6);
    wr(8'h99, 8'h01); wr(8'h88, 8'h02); rd(8'h88, 8'h00); chk(irq, 0);
    wr(8'h8e, 8'h08);
    for (i = 0; i < 16; i++) rd(8'h8f, 8'ha0 + i);
    $display("transfer done");
    slow <= 1; s = n_st;
    wr(8'h8e, 8'h01); wr(8'h8e, 8'h01); wr(8'h8e, 8'h00); wt;
    rd(8'h88, 8'h10); chk(n_st - s, 1); wr(8'h88, 8'hff);
    for (i = 0; i < 2; i++) begin
      wr(8'h8e, i ? 8'h11 : 8'h05); repeat (5) @(posedge clk);
      {fcs, cont} <= i ? 2'b10 : 2'b01; @(posedge clk);
      {fcs, cont} <= 2'b00; wt;
      rd(8'h88, i ? 8'h08 : 8'h40); wr(8'h88, 8'hff);
    end
    $display("kill and abort done");
    wr(8'h9b, 8'h01); chk(mo, 1); rd(8'h9b, 8'h01);
    wr(8'h9b, 8'h00); chk(mo, 0);
    slow <= 0;
    // fast rates: a launch due mid-transfer is skipped, so one every 40 cycles
    for (i = 0; i < 4; i++) begin
      s = n_st; wr(8'h8e, {i[1:0], 6'h20}); repeat (700) @(posedge clk);
      wr(8'h8e, 8'h00); wt; r = n_st - s; k = 700 / (i < 2 ? 40 : (20 << i));
      chk(r >= k && r <= k + 1, 1);
    end
    $display("periodic done");
    stop_test;
  end
endmodule // tb
